// *** design/fmd_consts.vh ***
`ifndef FMD_CONSTS_VH
`define FMD_CONSTS_VH
// register select codes on the data buses
`define FMD_R_XL 4'h0
`define FMD_R_XH 4'h1
`define FMD_R_YL 4'h2
`define FMD_R_YH 4'h3
`define FMD_R_AL 4'h4
`define FMD_R_AU 4'h5
`define FMD_R_AG 4'h6
`define FMD_R_BL 4'h8
`define FMD_R_BU 4'h9
`define FMD_R_BG 4'ha
`define FMD_R_A 4'hc
`define FMD_R_B 4'hd
`define FMD_R_X 4'he
`define FMD_R_Y 4'hf
// operation codes
`define FMD_OP_NOP 4'h0
`define FMD_OP_MPY 4'h1
`define FMD_OP_MAC 4'h2
`define FMD_OP_RND 4'h3
`define FMD_OP_ADD 4'h4
`define FMD_OP_SUB 4'h5
`define FMD_OP_AND 4'h6
`define FMD_OP_OR 4'h7
`define FMD_OP_XOR 4'h8
`define FMD_OP_NOT 4'h9
`define FMD_OP_TFR 4'ha
`define FMD_OP_ASL 4'hb
`define FMD_OP_ASR 4'hc
`define FMD_OP_CLR 4'hd
`define FMD_OP_DIV 4'he
`define FMD_OP_NRM 4'hf
// scaling modes
`define FMD_SC_NONE 2'h0
`define FMD_SC_DOWN 2'h1
`define FMD_SC_UP 2'h2
// saturation constants
`define FMD_SAT_POS 24'h7fffff
`define FMD_SAT_NEG 24'h800000
`define FMD_SAT_POS_LO 24'hffffff
`define FMD_SAT_NEG_LO 24'h000000
`endif

// *** design/fmd_datapath.v ***
`include "fmd_consts.vh"

// Overview of operation
// - four 24-bit inputs, pairable high:low
// - all registers readable/writable on either bus
// - operands internal, results go to accumulator
// - every operation finishes in one cycle
// - multiplier inputs latched before same-cycle writes
// - signed fractional 24x24 multiply from inputs
// - product added to full 56-bit accumulator
// - 8-bit extension; accumulators add to each other
// - multiply-only clears destination first
// - results sign extended, zero filled 56 bits
// - optional convergent rounding, else truncate
// - rounding position follows scaling mode
// - logic ops on upper word only
// - guard, upper, lower individually addressable
// - extension-in-use flag when guard used
// - word write: upper, zero lower, extend
// - long write: upper, lower, extend
// - transfers extend; part writes do not
// - full read shifted then limited
// - part reads bypass shift and limit
// - overflow test after data shifter
// - saturate to max magnitude with sign
// - sticky limit flag until cleared
// - round down below half, up above
module fmd_datapath #(
	parameter W = 24
) (
	// clock and reset
	input wire clk_in,
	input wire rst_b_in,
	input wire ce_in,
	// instruction control
	input wire [3:0] op_in,
	input wire op_dst_b_in,
	input wire op_sub_in,
	input wire op_round_in,
	input wire [1:0] op_src1_in,
	input wire [1:0] op_src2_in,
	input wire op_src_acc_in,
	input wire [1:0] scale_mode_in,
	input wire limit_clear_in,
	// x data bus
	input wire xw_en_in,
	input wire [3:0] xw_sel_in,
	input wire [W-1:0] xw_data_in,
	input wire [3:0] xr_sel_in,
	// y data bus
	input wire yw_en_in,
	input wire [3:0] yw_sel_in,
	input wire [W-1:0] yw_data_in,
	input wire [3:0] yr_sel_in,
	// read results and status
	output reg [W-1:0] x_data_bus_out,
	output reg [W-1:0] y_data_bus_out,
	output reg ext_in_use_out,
	output reg limit_flag_out
);
	localparam AW = 2*W+8;
	reg [W-1:0] x_input_high, x_input_low, y_input_high, y_input_low;
	reg [7:0] acc_a_guard, acc_b_guard;
	reg [W-1:0] acc_a_upper, acc_a_lower, acc_b_upper, acc_b_lower;
	wire [AW-1:0] acc_a = {acc_a_guard, acc_a_upper, acc_a_lower};
	wire [AW-1:0] acc_b = {acc_b_guard, acc_b_upper, acc_b_lower};

	// operand selection uses values before this edge's writes
	function [W-1:0] pick_in;
		input [1:0] s;
		begin
			case (s)
				2'h0: pick_in = x_input_low;
				2'h1: pick_in = x_input_high;
				2'h2: pick_in = y_input_low;
				default: pick_in = y_input_high;
			endcase
		end
	endfunction

	wire [W-1:0] m1 = pick_in(op_src1_in);
	wire [W-1:0] m2 = pick_in(op_src2_in);
	wire signed [2*W-1:0] raw_prod = $signed(m1) * $signed(m2);
	// fractional: shift out duplicate sign
	wire [2*W-1:0] prod = {raw_prod[2*W-2:0], 1'b0};
	wire [AW-1:0] prod_ext = {{8{prod[2*W-1]}}, prod};

	// destination and the opposite accumulator for add, subtract and transfer
	// the input pair is sign extended into the guard byte before use
	wire [AW-1:0] dst = op_dst_b_in ? acc_b : acc_a;
	wire [AW-1:0] other = op_dst_b_in ? acc_a : acc_b;
	wire [AW-1:0] in_pair = op_src1_in[1] ? {{8{y_input_high[W-1]}}, y_input_high, y_input_low}
		: {{8{x_input_high[W-1]}}, x_input_high, x_input_low};
	wire [AW-1:0] add_src = op_src_acc_in ? other : in_pair;

	// rounding position: higher bit when scaling down, lower when up
	reg [AW-1:0] rnd_half, rnd_mask;
	always @* begin
		case (scale_mode_in)
			`FMD_SC_DOWN: begin
				rnd_half = {{(AW-W-1){1'b0}}, 1'b1, {W{1'b0}}};
				rnd_mask = {{(AW-W-1){1'b1}}, 1'b0, {W{1'b0}}};
			end
			`FMD_SC_UP: begin
				rnd_half = {{(AW-W+1){1'b0}}, 1'b1, {(W-2){1'b0}}};
				rnd_mask = {{(AW-W+1){1'b1}}, 1'b0, {(W-2){1'b0}}};
			end
			default: begin
				rnd_half = {{(AW-W){1'b0}}, 1'b1, {(W-1){1'b0}}};
				rnd_mask = {{(AW-W){1'b1}}, {W{1'b0}}};
			end
		endcase
	end

	// convergent rounding: ties go to even
	function [AW-1:0] do_round;
		input [AW-1:0] v;
		input [AW-1:0] half;
		input [AW-1:0] mask;
		reg [AW-1:0] s;
		reg tie;
		begin
			s = v + half;
			tie = ((v & ~mask) == half);
			do_round = s & mask;
			if (tie) begin
				do_round = s & mask & ~(half << 1);
			end
		end
	endfunction

	// next accumulator value from the operation
	reg [AW-1:0] res;
	reg res_en;
	reg [AW-1:0] base;
	always @* begin
		res = dst;
		res_en = 1'b1;
		base = (op_in == `FMD_OP_MPY) ? {AW{1'b0}} : dst;
		case (op_in)
			`FMD_OP_MPY, `FMD_OP_MAC: begin
				res = op_sub_in ? base - prod_ext : base + prod_ext;
				if (op_round_in) begin
					res = do_round(res, rnd_half, rnd_mask);
				end
			end
			`FMD_OP_RND: res = do_round(dst, rnd_half, rnd_mask);
			`FMD_OP_ADD: res = dst + add_src;
			`FMD_OP_SUB: res = dst - add_src;
			`FMD_OP_AND: res = {dst[AW-1:2*W], dst[2*W-1:W] & pick_in(op_src1_in), dst[W-1:0]};
			`FMD_OP_OR: res = {dst[AW-1:2*W], dst[2*W-1:W] | pick_in(op_src1_in), dst[W-1:0]};
			`FMD_OP_XOR: res = {dst[AW-1:2*W], dst[2*W-1:W] ^ pick_in(op_src1_in), dst[W-1:0]};
			`FMD_OP_NOT: res = {dst[AW-1:2*W], ~dst[2*W-1:W], dst[W-1:0]};
			`FMD_OP_TFR: res = add_src;
			`FMD_OP_ASL: res = {dst[AW-2:0], 1'b0};
			`FMD_OP_ASR: res = {dst[AW-1], dst[AW-1:1]};
			`FMD_OP_CLR: res = {AW{1'b0}};
			`FMD_OP_DIV: begin
				// one restoring-free divide step on the upper part
				res = {dst[AW-2:0], 1'b0};
				// divisor comes from the latched first operand
				if (dst[AW-1] ^ m1[W-1]) begin
					res = res + {8'h00, m1, {W{1'b0}}};
				end else begin
					res = res - {8'h00, m1, {W{1'b0}}};
				end
			end
			`FMD_OP_NRM: begin
				// shift left once while not yet normalised
				if (dst[AW-1:2*W-2] == {(AW-2*W+2){1'b0}} || dst[AW-1:2*W-2] == {(AW-2*W+2){1'b1}}) begin
					res = {dst[AW-2:0], 1'b0};
				end
			end
			default: res_en = 1'b0;
		endcase
	end

	// data shifter and limiter per bus
	function [AW-1:0] scale;
		input [AW-1:0] v;
		input [1:0] m;
		begin
			case (m)
				`FMD_SC_DOWN: scale = {v[AW-1], v[AW-1:1]};
				`FMD_SC_UP: scale = {v[AW-2:0], 1'b0};
				default: scale = v;
			endcase
		end
	endfunction

	wire [AW-1:0] sh_a = scale(acc_a, scale_mode_in);
	wire [AW-1:0] sh_b = scale(acc_b, scale_mode_in);
	// overflow test: bits above the upper word not all equal to sign
	wire ovf_a = ~((&sh_a[AW-1:2*W-1]) | ~(|sh_a[AW-1:2*W-1])) | (scale_mode_in == `FMD_SC_UP && acc_a[AW-1] != acc_a[AW-2]);
	wire ovf_b = ~((&sh_b[AW-1:2*W-1]) | ~(|sh_b[AW-1:2*W-1])) | (scale_mode_in == `FMD_SC_UP && acc_b[AW-1] != acc_b[AW-2]);

	function [W:0] rd_val;
		input [3:0] sel;
		input hi;
		reg [AW-1:0] v;
		reg o;
		begin
			v = sh_a;
			o = ovf_a;
			if (sel == `FMD_R_B || sel == `FMD_R_BL || sel == `FMD_R_BU || sel == `FMD_R_BG) begin
				v = sh_b;
				o = ovf_b;
			end
			case (sel)
				`FMD_R_XL: rd_val = {1'b0, x_input_low};
				`FMD_R_XH: rd_val = {1'b0, x_input_high};
				`FMD_R_YL: rd_val = {1'b0, y_input_low};
				`FMD_R_YH: rd_val = {1'b0, y_input_high};
				`FMD_R_X: rd_val = {1'b0, hi ? x_input_high : x_input_low};
				`FMD_R_Y: rd_val = {1'b0, hi ? y_input_high : y_input_low};
				`FMD_R_AL: rd_val = {1'b0, acc_a_lower};
				`FMD_R_AU: rd_val = {1'b0, acc_a_upper};
				`FMD_R_AG: rd_val = {{(W-7){acc_a_guard[7]}}, acc_a_guard};
				`FMD_R_BL: rd_val = {1'b0, acc_b_lower};
				`FMD_R_BU: rd_val = {1'b0, acc_b_upper};
				`FMD_R_BG: rd_val = {{(W-7){acc_b_guard[7]}}, acc_b_guard};
				`FMD_R_A, `FMD_R_B: begin
					if (o) begin
						rd_val = {1'b1, hi ? (v[AW-1] ? `FMD_SAT_NEG : `FMD_SAT_POS)
							: (v[AW-1] ? `FMD_SAT_NEG_LO : `FMD_SAT_POS_LO)};
					end else begin
						rd_val = {1'b0, hi ? v[2*W-1:W] : v[W-1:0]};
					end
				end
				default: rd_val = {(W+1){1'b0}};
			endcase
		end
	endfunction

	// limiting only for full accumulator sources, never for part registers
	// a long read drives high word on x and low word on y when both name the same pair
	wire long_rd = (xr_sel_in == yr_sel_in) && (xr_sel_in[3:2] == 2'b11);
	wire [W:0] xr = rd_val(xr_sel_in, 1'b1);
	wire [W:0] yr = rd_val(yr_sel_in, ~long_rd);
	wire lim_now = (xr_sel_in[3:1] == 3'b110 && xr[W]) || (yr_sel_in[3:1] == 3'b110 && yr[W]);

	// bus writes: a long write has the same full-register select on both buses
	wire long_wr = xw_en_in && yw_en_in && (xw_sel_in == yw_sel_in) && (xw_sel_in[3:2] == 2'b11);

	// next register values, writes override the operation result
	reg [W-1:0] next_xh, next_xl, next_yh, next_yl;
	reg [AW-1:0] next_a, next_b;
	always @* begin
		next_xh = x_input_high;
		next_xl = x_input_low;
		next_yh = y_input_high;
		next_yl = y_input_low;
		next_a = (res_en && !op_dst_b_in) ? res : acc_a;
		next_b = (res_en && op_dst_b_in) ? res : acc_b;
		if (long_wr) begin
			case (xw_sel_in)
				`FMD_R_X: begin
					next_xh = xw_data_in;
					next_xl = yw_data_in;
				end
				`FMD_R_Y: begin
					next_yh = xw_data_in;
					next_yl = yw_data_in;
				end
				`FMD_R_A: next_a = {{8{xw_data_in[W-1]}}, xw_data_in, yw_data_in};
				default: next_b = {{8{xw_data_in[W-1]}}, xw_data_in, yw_data_in};
			endcase
		end else begin
			if (xw_en_in) begin
				wr_one(xw_sel_in, xw_data_in);
			end
			if (yw_en_in) begin
				wr_one(yw_sel_in, yw_data_in);
			end
		end
	end

	task wr_one;
		input [3:0] sel;
		input [W-1:0] d;
		begin
			case (sel)
				`FMD_R_XL, `FMD_R_X: next_xl = d;
				`FMD_R_XH: next_xh = d;
				`FMD_R_YL, `FMD_R_Y: next_yl = d;
				`FMD_R_YH: next_yh = d;
				`FMD_R_AL: next_a = {next_a[AW-1:W], d};
				`FMD_R_AU: next_a = {next_a[AW-1:2*W], d, next_a[W-1:0]};
				`FMD_R_AG: next_a = {d[7:0], next_a[2*W-1:0]};
				`FMD_R_BL: next_b = {next_b[AW-1:W], d};
				`FMD_R_BU: next_b = {next_b[AW-1:2*W], d, next_b[W-1:0]};
				`FMD_R_BG: next_b = {d[7:0], next_b[2*W-1:0]};
				`FMD_R_A: next_a = {{8{d[W-1]}}, d, {W{1'b0}}};
				`FMD_R_B: next_b = {{8{d[W-1]}}, d, {W{1'b0}}};
				default: next_xl = next_xl;
			endcase
		end
	endtask

	// flag follows the values that this edge will store,
	// so it reflects bus writes as well as operation results
	// guard in use when the top bits are not all sign
	wire a_ext = ~((&next_a[AW-1:2*W-1]) | ~(|next_a[AW-1:2*W-1]));
	wire b_ext = ~((&next_b[AW-1:2*W-1]) | ~(|next_b[AW-1:2*W-1]));

	// one edge commits every register, read result and flag together
	// limit flag: a new limit wins over a clear in the same cycle
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			x_input_high <= 24'h000000;
			x_input_low <= 24'h000000;
			y_input_high <= 24'h000000;
			y_input_low <= 24'h000000;
			acc_a_guard <= 8'h00;
			acc_a_upper <= 24'h000000;
			acc_a_lower <= 24'h000000;
			acc_b_guard <= 8'h00;
			acc_b_upper <= 24'h000000;
			acc_b_lower <= 24'h000000;
			x_data_bus_out <= 24'h000000;
			y_data_bus_out <= 24'h000000;
			ext_in_use_out <= 1'b0;
			limit_flag_out <= 1'b0;
		end else if (ce_in) begin
			x_input_high <= next_xh;
			x_input_low <= next_xl;
			y_input_high <= next_yh;
			y_input_low <= next_yl;
			{acc_a_guard, acc_a_upper, acc_a_lower} <= next_a;
			{acc_b_guard, acc_b_upper, acc_b_lower} <= next_b;
			x_data_bus_out <= xr[W-1:0];
			y_data_bus_out <= yr[W-1:0];
			ext_in_use_out <= a_ext | b_ext;
			if (lim_now) begin
				limit_flag_out <= 1'b1;
			end else if (limit_clear_in) begin
				limit_flag_out <= 1'b0;
			end
		end
	end
endmodule // fmd_datapath

// *** tb/fmd_bus_mem.sv ***
module fmd_bus_mem (
	// store side
	input logic clk_in,
	input logic st_in,
	input logic [23:0] data_in,
	// load side
	input logic ld_in,
	output logic [23:0] data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [23:0] word = 24'h0;
	logic [23:0] last = 24'h0;
	always @(posedge clk_in) begin
		if (st_in) word <= data_in;
		if (ld_in) last <= word;
	end
	// a released bus shows the inverse of its last word, not a stale copy
	assign data_out = ld_in ? word : ~last;
endmodule // fmd_bus_mem

// *** tb/fmd_dp_properties.sv ***
`include "fmd_consts.vh"
module fmd_dp_properties #(
	parameter W = 24
) (
	// control inputs
	input logic clk_in,
	input logic rst_b_in,
	input logic ce_in,
	input logic [3:0] op_in,
	input logic op_dst_b_in,
	input logic op_sub_in,
	input logic op_round_in,
	input logic [1:0] op_src1_in,
	input logic [1:0] op_src2_in,
	input logic op_src_acc_in,
	input logic [1:0] scale_mode_in,
	input logic limit_clear_in,
	input logic xw_en_in,
	input logic [3:0] xw_sel_in,
	input logic [W-1:0] xw_data_in,
	input logic [3:0] xr_sel_in,
	input logic yw_en_in,
	input logic [3:0] yw_sel_in,
	input logic [W-1:0] yw_data_in,
	input logic [3:0] yr_sel_in,
	// results
	input logic [W-1:0] x_data_bus_out,
	input logic [W-1:0] y_data_bus_out,
	input logic ext_in_use_out,
	input logic limit_flag_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// full accumulator read on either bus
	wire full_rd = xr_sel_in[3:1] == 3'b110 || yr_sel_in[3:1] == 3'b110;
	wire full_rd_en = ce_in && full_rd;
	a_ce_freeze: assert property (!ce_in |=> $stable({x_data_bus_out, y_data_bus_out, ext_in_use_out, limit_flag_out}))
		else $error("outputs moved while clock enable low");
	a_limit_sticky: assert property (limit_flag_out && !limit_clear_in |=> limit_flag_out)
		else $error("limit flag dropped without clear");
	a_limit_cause: assert property ($rose(limit_flag_out) |-> $past(full_rd_en))
		else $error("limit flag set without full accumulator read");
	a_part_nolimit: assert property (!limit_flag_out && !full_rd |=> !limit_flag_out)
		else $error("limit flag set by part read");
	a_limit_clear: assert property (ce_in && limit_clear_in && !full_rd |=> !limit_flag_out)
		else $error("limit flag not cleared");
	a_input_rw: assert property (ce_in && xw_en_in && xw_sel_in == `FMD_R_XL && !yw_en_in ##1
		ce_in && xr_sel_in == `FMD_R_XL |=> x_data_bus_out == $past(xw_data_in, 2))
		else $error("input register readback wrong");
	a_word_ext: assert property (ce_in && xw_en_in && xw_sel_in == `FMD_R_A && !yw_en_in ##1
		ce_in && xr_sel_in == `FMD_R_AG |=> x_data_bus_out == {W{$past(xw_data_in[W-1], 2)}})
		else $error("guard not sign extended on word write");
	a_guard_read: assert property (ce_in && yr_sel_in == `FMD_R_BG |=> y_data_bus_out[W-1:8] == {(W-8){y_data_bus_out[7]}})
		else $error("guard read not sign extended");
endmodule // fmd_dp_properties

// *** tb/tb_top.sv ***
`include "fmd_consts.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 0, rst_b_in = 0, ce_in = 1, op_dst_b_in = 0, op_sub_in = 0, op_round_in = 0;
	logic [3:0] op_in = 0, xw_sel_in = 0, xr_sel_in = 0, yw_sel_in = 0, yr_sel_in = 0;
	logic op_src_acc_in = 0, limit_clear_in = 0, xw_en_in = 0, yw_en_in = 0, st = 0, ld = 0, lim = 0;
	logic [1:0] op_src1_in = 0, op_src2_in = 0, scale_mode_in = 0;
	logic [23:0] xw_data_in = 0, pd = 0, yw_data_in, x_data_bus_out, y_data_bus_out, xh, xl, yh, yl;
	logic ext_in_use_out, limit_flag_out;
	logic [23:0] qx[$], qy[$];
	logic [1:0] qf[$];
	logic [55:0] ma, mb, p;
	logic [31:0] seed = 32'hccaa;
	int fails = 0, n_checks = 0, cyc = 0;
	fmd_datapath dut (.*);
	fmd_bus_mem mem (.clk_in(clk_in), .st_in(st), .data_in(pd), .ld_in(ld), .data_out(yw_data_in));
	initial forever #25 clk_in = ~clk_in;
	function automatic logic [23:0] rnd;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[23:0];
	endfunction
	function automatic logic [55:0] prod(logic [23:0] a, b);
		logic signed [55:0] sa = $signed(a), sb = $signed(b);
		return (sa * sb) <<< 1;
	endfunction
	function automatic logic [55:0] cround(logic [55:0] v);
		logic [55:0] r = v + 56'h800000;
		if (v[23:0] == 24'h800000) r[24] = 1'b0;
		r[23:0] = 24'h0;
		return r;
	endfunction
	function automatic logic use8(logic [55:0] v);
		return v[55:47] != 9'h0 && v[55:47] != 9'h1ff;
	endfunction
	task stop_test;
		$display("checks %0d, fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task cmpw(string n, logic [23:0] e, g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	task tick;
		@(posedge clk_in);
		#2;
	endtask
	task run;
		tick;
		{xw_en_in, yw_en_in, ld, op_in, limit_clear_in} = 8'h0;
		tick;
	endtask
	task rd(logic [3:0] xs, logic [23:0] xe, logic [3:0] ys, logic [23:0] ye);
		{xr_sel_in, yr_sel_in} = {xs, ys};
		qx.push_back(xe);
		qy.push_back(ye);
		qf.push_back({use8(ma) || use8(mb), lim});
		run;
	endtask
	task ca(logic [3:0] b, logic [55:0] v);
		rd(b + 4'h1, v[47:24], b, v[23:0]);
		rd(b + 4'h2, {{16{v[55]}}, v[55:48]}, b + 4'h2, {{16{v[55]}}, v[55:48]});
	endtask
	task wy(logic [3:0] s, logic [23:0] d);
		{st, pd} = {1'b1, d};
		tick;
		{st, ld, yw_en_in, yw_sel_in} = {3'b011, s};
	endtask
	task wx(logic [3:0] s, logic [23:0] d);
		{xw_en_in, xw_sel_in, xw_data_in} = {1'b1, s, d};
	endtask
	task op(logic [3:0] o, logic b, s, r, logic [1:0] s1, s2);
		{op_in, op_dst_b_in, op_sub_in, op_round_in, op_src1_in, op_src2_in} = {o, b, s, r, s1, s2};
	endtask
	task aop(logic [3:0] o);
		op(o, 1, 0, 0, 2'h0, 2'h0);
		op_src_acc_in = 1;
		run;
		op_src_acc_in = 0;
	endtask
	always @(posedge clk_in) begin
		#1;
		if (qx.size()) begin
			cmpw("x bus", qx.pop_front(), x_data_bus_out);
			cmpw("y bus", qy.pop_front(), y_data_bus_out);
		end
		if (qf.size()) cmpw("flags", qf.pop_front(), {ext_in_use_out, limit_flag_out});
	end
	always @(posedge clk_in) if (++cyc == 2000) begin
		fails++;
		stop_test;
	end
	initial begin
		repeat (2) tick;
		rst_b_in = 1;
		{ma, mb} = 112'h0;
		ca(`FMD_R_AL, ma);
		ca(`FMD_R_BL, mb);
		{xh, xl, yh, yl} = {rnd(), rnd(), rnd(), rnd()};
		xr_sel_in = `FMD_R_XL;
		wx(`FMD_R_XL, xl);
		run;
		wy(`FMD_R_YL, yl);
		wx(`FMD_R_XH, xh);
		run;
		wy(`FMD_R_YH, yh);
		run;
		rd(`FMD_R_XH, xh, `FMD_R_YL, yl);
		rd(`FMD_R_X, xh, `FMD_R_X, xl);
		rd(`FMD_R_Y, yh, `FMD_R_Y, yl);
		$display("input registers done");
		wy(`FMD_R_A, rnd());
		wx(`FMD_R_A, rnd());
		run;
		op(`FMD_OP_MPY, 0, 0, 0, 2'h1, 2'h3);
		wx(`FMD_R_XH, ~xh);
		run;
		ma = prod(xh, yh);
		ca(`FMD_R_AL, ma);
		rd(`FMD_R_XH, ~xh, `FMD_R_YH, yh);
		for (int k = 0; k < 8; k++) begin
			op(k[2] ? `FMD_OP_MAC : `FMD_OP_MPY, 1, k[0], k[1], 2'h0, 2'h2);
			run;
			p = k[0] ? -prod(xl, yl) : prod(xl, yl);
			mb = k[2] ? mb + p : p;
			if (k[1]) mb = cround(mb);
			ca(`FMD_R_BL, mb);
		end
		$display("multiply done");
		for (int k = 0; k < 4; k++) begin
			op(`FMD_OP_AND + k, 0, 0, 0, 2'h0, 2'h0);
			run;
			case (k)
				0: ma[47:24] &= xl;
				1: ma[47:24] |= xl;
				2: ma[47:24] ^= xl;
				default: ma[47:24] = ~ma[47:24];
			endcase
			ca(`FMD_R_AL, ma);
		end
		op(`FMD_OP_TFR, 1, 0, 0, 2'h0, 2'h0);
		run;
		mb = {{8{~xh[23]}}, ~xh, xl};
		ca(`FMD_R_BL, mb);
		for (int k = 0; k < 5; k++) begin
			op(k == 4 ? `FMD_OP_CLR : k == 3 ? `FMD_OP_NRM : k == 2 ? `FMD_OP_ASR : k == 1 ? `FMD_OP_ASL : `FMD_OP_RND,
				1, 0, 0, 2'h0, 2'h0);
			run;
			case (k)
				0: mb = cround(mb);
				1: mb = mb << 1;
				2: mb = {mb[55], mb[55:1]};
				3: if (mb[55:46] == 10'h0 || mb[55:46] == 10'h3ff) mb = mb << 1;
				default: mb = 56'h0;
			endcase
			ca(`FMD_R_BL, mb);
		end
		$display("logic and transfer done");
		xr_sel_in = `FMD_R_AG;
		wx(`FMD_R_A, 24'h400000);
		run;
		wy(`FMD_R_B, 24'h0);
		wx(`FMD_R_B, 24'h7fffff);
		run;
		{ma, mb} = {56'h400000000000, 56'h7fffff000000};
		aop(`FMD_OP_ADD);
		mb = mb + ma;
		ca(`FMD_R_BL, mb);
		lim = 1;
		rd(`FMD_R_B, `FMD_SAT_POS, `FMD_R_AU, 24'h400000);
		rd(`FMD_R_B, `FMD_SAT_POS, `FMD_R_B, `FMD_SAT_POS_LO);
		wy(`FMD_R_B, 24'h0);
		wx(`FMD_R_B, 24'h800000);
		run;
		aop(`FMD_OP_SUB);
		mb = 56'hff800000000000 - ma;
		rd(`FMD_R_B, `FMD_SAT_NEG, `FMD_R_B, `FMD_SAT_NEG_LO);
		wx(`FMD_R_BU, 24'h123456);
		run;
		mb[47:24] = 24'h123456;
		ca(`FMD_R_BL, mb);
		limit_clear_in = 1;
		lim = 0;
		rd(`FMD_R_XL, xl, `FMD_R_YL, yl);
		$display("limiting done");
		scale_mode_in = `FMD_SC_DOWN;
		rd(`FMD_R_A, 24'h200000, `FMD_R_AU, 24'h400000);
		scale_mode_in = `FMD_SC_UP;
		lim = 1;
		rd(`FMD_R_A, `FMD_SAT_POS, `FMD_R_XL, xl);
		scale_mode_in = `FMD_SC_NONE;
		ce_in = 0;
		wx(`FMD_R_XL, ~xl);
		run;
		ce_in = 1;
		rd(`FMD_R_XL, xl, `FMD_R_YL, yl);
		$display("scaling and enable done");
		stop_test;
	end
endmodule // tb_top
bind fmd_datapath fmd_dp_properties #(.W(W)) u_chk (.*);
